// ### common/rcb_pkg.sv
/*
 * shared constants and types of the calendar clock with backup storage.
 * assumes a single 200 mhz system clock and calendar sources sampled as pins.
 */
package rcb_pkg;
	// -----------------------------------------------------------------
	// sizes and counts
	// -----------------------------------------------------------------
	localparam int unsigned BKP_WORDS = 5;
	localparam int unsigned BKP_WIDTH = 32;
	localparam int unsigned FAST_DIV_DEF = 32;
	localparam logic [14:0] PREDIV_RST = 15'h7fff;
	localparam logic [19:0] CAL_PLUS_ADD = 20'h00200;
	localparam logic [5:0] REF50_LAST = 6'h31;
	localparam logic [5:0] REF60_LAST = 6'h3b;

	// -----------------------------------------------------------------
	// pin slots of the input filter bank
	// -----------------------------------------------------------------
	localparam int unsigned PIN_XTAL = 0;
	localparam int unsigned PIN_RC = 1;
	localparam int unsigned PIN_FAST = 2;
	localparam int unsigned PIN_TAMP0 = 3;
	localparam int unsigned PIN_TAMP1 = 4;
	localparam int unsigned PIN_TS = 5;
	localparam int unsigned PIN_REF = 6;
	localparam int unsigned PIN_COUNT = 7;

	// -----------------------------------------------------------------
	// types
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_XTAL = 2'b00,
		SRC_RC = 2'b01,
		SRC_FAST = 2'b10
	} rcb_src_t;

	typedef struct packed {
		logic [14:0] ss;
		logic [6:0] sec;
		logic [6:0] min;
		logic pm;
		logic [5:0] hour;
		logic [2:0] wday;
		logic [5:0] date;
		logic [4:0] month;
		logic [7:0] year;
	} rcb_cal_t;

	typedef struct packed {
		logic [3:0] msk;
		logic [6:0] sec;
		logic [6:0] min;
		logic pm;
		logic [5:0] hour;
		logic [5:0] date;
	} rcb_alarm_t;

	typedef struct packed {
		logic ts;
		logic [1:0] tamp;
		logic wut;
		logic alrb;
		logic alra;
	} rcb_flags_t;

	localparam rcb_cal_t CAL_RST = '{ss: PREDIV_RST, sec: 7'h00, min: 7'h00, pm: 1'b0,
		hour: 6'h00, wday: 3'h1, date: 6'h01, month: 5'h01, year: 8'h00};
endpackage : rcb_pkg

// ### logic/rcb_pin_filter.sv
/*
 * one pin: two-flop synchroniser, stability filter and rising-edge pulse.
 * assumes the pin is asynchronous to clk_sys and much slower than it.
 */
`timescale 1ns/1ps
module rcb_pin_filter (
	// clock and reset
	input logic clk_sys,
	input logic rst_n,
	// pin and filter depth
	input logic pin,
	input logic [1:0] filt,
	// filtered result
	output logic level,
	output logic rise
);
	logic sync1;
	logic sync2;
	logic [3:0] cnt;
	wire [3:0] need = (4'h1 << filt) - 4'h1;
	wire differ = sync2 != level;
	wire accept = differ && (cnt == need);

	// synchroniser; only sync2 reads sync1
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
		end else begin
			sync1 <= pin;
			sync2 <= sync1;
		end
	end

	// a new level must hold for 2^filt samples before it is taken
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cnt <= 4'h0;
			level <= 1'b0;
			rise <= 1'b0;
		end else begin
			cnt <= (differ && !accept) ? cnt + 4'h1 : 4'h0;
			if (accept) begin
				level <= sync2;
			end
			rise <= accept && sync2;
		end
	end
endmodule : rcb_pin_filter

// ### logic/rcb_top.sv
/*
 * calendar clock with backup words, alarms, wakeup timer, tamper and timestamp.
 * assumes this logic sits in the always-on domain and all config ports are
 * driven synchronously to clk_sys; calendar sources arrive as pins.
 */
`timescale 1ns/1ps
// Contract
// - five backup words of 32 bits, 20 bytes of user data.
// - backup words are never cleared by reset or standby wake.
// - calendar and backup stay powered and running in all modes.
// - bcd calendar from subseconds to year, 12 or 24 hour format.
// - month end uses 28, 29 leap, 30 or 31 days automatically.
// - two independent alarms, each able to wake the device.
// - periodic wakeup timer with programmable resolution and period.
// - on-the-fly shift of 1 to 32767 calendar clock pulses.
// - optional 50 or 60 hz reference resynchronises the second.
// - digital calibration adjusts the rate in steps of one pulse per 2^20, 0.954 ppm.
// - two tamper pins through a programmable filter, waking the device.
// - timestamp pin or tamper captures the calendar and wakes.
// - calendar source is slow crystal, slow rc or divided fast clock.
module rcb_top #(
	parameter int unsigned FAST_DIV = rcb_pkg::FAST_DIV_DEF
) (
	// clock and reset
	input logic clk_sys,
	input logic rst_n,
	// calendar clock pins
	input logic slow_crystal_clock,
	input logic slow_internal_rc_clock,
	input logic fast_external_clock,
	// event pins
	input logic [1:0] tamper_pin,
	input logic timestamp_pin,
	input logic ref_clock_pin,
	// configuration
	input rcb_pkg::rcb_src_t src_sel,
	input logic [14:0] prediv,
	input logic fmt_12h,
	input logic [8:0] cal_minus,
	input logic cal_plus,
	input logic ref_en,
	input logic ref_60hz,
	input logic wut_en,
	input logic [1:0] wut_sel,
	input logic [15:0] wut_reload,
	input logic [1:0] alarm_en,
	input rcb_pkg::rcb_alarm_t alarm_a,
	input rcb_pkg::rcb_alarm_t alarm_b,
	input logic [1:0] tamp_en,
	input logic [1:0] tamp_filt,
	input logic ts_en,
	// calendar load and shift
	input logic cal_set,
	input rcb_pkg::rcb_cal_t cal_wdata,
	input logic shift_req,
	input logic [14:0] shift_sub,
	input logic shift_add1s,
	// backup words
	input logic bkp_we,
	input logic [2:0] bkp_idx,
	input logic [31:0] bkp_wdata,
	output logic [31:0] bkp_rdata,
	// status
	output rcb_pkg::rcb_cal_t cal_now,
	output rcb_pkg::rcb_cal_t ts_cal,
	output rcb_pkg::rcb_flags_t flags,
	input rcb_pkg::rcb_flags_t flag_clr,
	output logic shift_busy,
	output logic wake_evt
);
	if (FAST_DIV < 2 || FAST_DIV > 256) begin : g_chk
		$error("FAST_DIV must lie in 2..256");
	end

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
	endfunction : bcd_inc

	function automatic logic [5:0] month_end(input logic [4:0] m, input logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
			: (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		case (m)
			5'h02: month_end = leap ? 6'h29 : 6'h28;
			5'h04, 5'h06, 5'h09, 5'h11: month_end = 6'h30;
			default: month_end = 6'h31;
		endcase
	endfunction : month_end

	function automatic logic alarm_hit(input rcb_pkg::rcb_alarm_t a, input rcb_pkg::rcb_cal_t c);
		alarm_hit = (a.msk[0] || a.sec == c.sec) && (a.msk[1] || a.min == c.min)
			&& (a.msk[2] || (a.hour == c.hour && a.pm == c.pm))
			&& (a.msk[3] || a.date == c.date);
	endfunction : alarm_hit

	// -----------------------------------------------------------------
	// pin filters
	// -----------------------------------------------------------------
	wire [6:0] pin_raw = {ref_clock_pin, timestamp_pin, tamper_pin, fast_external_clock,
		slow_internal_rc_clock, slow_crystal_clock};
	wire [6:0] pin_rise;

	for (genvar gi = 0; gi < rcb_pkg::PIN_COUNT; gi++) begin : g_pin
		rcb_pin_filter u_flt (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.pin(pin_raw[gi]),
			.filt((gi == rcb_pkg::PIN_TAMP0 || gi == rcb_pkg::PIN_TAMP1) ? tamp_filt : 2'h0),
			.level(),
			.rise(pin_rise[gi])
		);
	end

	// -----------------------------------------------------------------
	// source select, calibration, shift, prescaler
	// -----------------------------------------------------------------
	logic [7:0] fast_cnt;
	logic [19:0] wcnt;
	logic [15:0] shift_pend;
	logic [5:0] ref_cnt;
	logic [15:0] wut_cnt;
	logic tick_q;
	logic day_carry;
	rcb_pkg::rcb_cal_t next_cal;
	rcb_pkg::rcb_flags_t next_flags;
	logic [31:0] bkp_mem [rcb_pkg::BKP_WORDS];

	wire fast_wrap = pin_rise[rcb_pkg::PIN_FAST] && fast_cnt == 8'(FAST_DIV - 1);
	wire src_pulse = (src_sel == rcb_pkg::SRC_XTAL) ? pin_rise[rcb_pkg::PIN_XTAL]
		: (src_sel == rcb_pkg::SRC_RC) ? pin_rise[rcb_pkg::PIN_RC]
		: (src_sel == rcb_pkg::SRC_FAST) && fast_wrap;
	// mask cal_minus pulses, double cal_plus*512 pulses in each 2^20 window
	wire cal_msk = wcnt < {11'h000, cal_minus};
	wire cal_ins = cal_plus && wcnt < rcb_pkg::CAL_PLUS_ADD;
	wire [1:0] step_raw = src_pulse ? 2'h1 + {1'b0, cal_ins} - {1'b0, cal_msk} : 2'h0;
	wire swallow = shift_busy && step_raw != 2'h0;
	wire [1:0] step = swallow ? 2'h0 : step_raw;
	wire shift_go = shift_req && !shift_busy;
	wire force_tick = shift_go && shift_add1s;
	wire presc_wrap = {13'h0000, step} > cal_now.ss;
	wire [14:0] presc_dec = cal_now.ss - {13'h0000, step};
	wire [14:0] next_ss = presc_wrap ? prediv + 15'h0001 + presc_dec : presc_dec;
	wire [5:0] ref_last = ref_60hz ? rcb_pkg::REF60_LAST : rcb_pkg::REF50_LAST;
	wire ref_sec = pin_rise[rcb_pkg::PIN_REF] && ref_cnt == ref_last;
	wire tick = (ref_en ? ref_sec : presc_wrap) || force_tick;
	wire [3:0] wdiv_msk = 4'hf >> (2'h3 - wut_sel);
	wire wut_base = (wut_sel == 2'h3) ? tick
		: src_pulse && (wcnt[3:0] & wdiv_msk) == wdiv_msk;
	wire wut_fire = wut_en && wut_base && wut_cnt == 16'h0000;
	wire [1:0] alm_hit = {tick_q && alarm_en[1] && alarm_hit(alarm_b, cal_now),
		tick_q && alarm_en[0] && alarm_hit(alarm_a, cal_now)};
	wire [1:0] tamp_evt = pin_rise[rcb_pkg::PIN_TAMP1:rcb_pkg::PIN_TAMP0] & tamp_en;
	wire ts_evt = (ts_en && pin_rise[rcb_pkg::PIN_TS]) || tamp_evt != 2'h0;
	wire [5:0] flag_set = {ts_evt, tamp_evt, wut_fire, alm_hit};
	// a set in the clearing cycle wins
	assign next_flags = rcb_pkg::rcb_flags_t'((flags & ~flag_clr) | flag_set);
	assign shift_busy = shift_pend != 16'h0000;

	// source counters and calibration window
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			fast_cnt <= 8'h00;
			wcnt <= 20'h00000;
			ref_cnt <= 6'h00;
			tick_q <= 1'b0;
		end else begin
			if (pin_rise[rcb_pkg::PIN_FAST]) begin
				fast_cnt <= fast_wrap ? 8'h00 : fast_cnt + 8'h01;
			end
			if (src_pulse) begin
				wcnt <= wcnt + 20'h00001;
			end
			if (pin_rise[rcb_pkg::PIN_REF]) begin
				ref_cnt <= ref_sec ? 6'h00 : ref_cnt + 6'h01;
			end
			tick_q <= tick;
		end
	end

	// pending shift: each pulse swallowed delays the clock by one
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			shift_pend <= 16'h0000;
		end else if (shift_go) begin
			shift_pend <= shift_add1s ? {1'b0, prediv} + 16'h0001 - {1'b0, shift_sub}
				: {1'b0, shift_sub};
		end else if (swallow) begin
			shift_pend <= shift_pend - 16'h0001;
		end
	end

	// -----------------------------------------------------------------
	// calendar
	// -----------------------------------------------------------------
	always_comb begin
		next_cal = cal_now;
		day_carry = 1'b0;
		next_cal.ss = (ref_en && ref_sec) ? prediv : next_ss;
		if (tick) begin
			next_cal.sec = (cal_now.sec == 7'h59) ? 7'h00 : 7'(bcd_inc({1'b0, cal_now.sec}));
			if (cal_now.sec == 7'h59) begin
				next_cal.min = (cal_now.min == 7'h59) ? 7'h00 : 7'(bcd_inc({1'b0, cal_now.min}));
				if (cal_now.min == 7'h59) begin
					if (fmt_12h) begin
						next_cal.hour = (cal_now.hour == 6'h12) ? 6'h01
							: 6'(bcd_inc({2'h0, cal_now.hour}));
						if (cal_now.hour == 6'h11) begin
							next_cal.pm = !cal_now.pm;
							day_carry = cal_now.pm;
						end
					end else begin
						next_cal.hour = (cal_now.hour == 6'h23) ? 6'h00
							: 6'(bcd_inc({2'h0, cal_now.hour}));
						day_carry = cal_now.hour == 6'h23;
					end
				end
			end
		end
		if (day_carry) begin
			next_cal.wday = (cal_now.wday == 3'h7) ? 3'h1 : cal_now.wday + 3'h1;
			if (cal_now.date == month_end(cal_now.month, cal_now.year)) begin
				next_cal.date = 6'h01;
				next_cal.month = (cal_now.month == 5'h12) ? 5'h01
					: 5'(bcd_inc({3'h0, cal_now.month}));
				if (cal_now.month == 5'h12) begin
					next_cal.year = (cal_now.year == 8'h99) ? 8'h00 : bcd_inc(cal_now.year);
				end
			end else begin
				next_cal.date = 6'(bcd_inc({2'h0, cal_now.date}));
			end
		end
		if (cal_set) begin
			next_cal = cal_wdata;
		end
	end

	// calendar, timestamp, flags, wakeup counter
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cal_now <= rcb_pkg::CAL_RST;
			ts_cal <= rcb_pkg::CAL_RST;
			flags <= '0;
			wake_evt <= 1'b0;
			wut_cnt <= 16'h0000;
		end else begin
			cal_now <= next_cal;
			if (ts_evt) begin
				ts_cal <= cal_now;
			end
			flags <= next_flags;
			wake_evt <= next_flags != '0;
			if (!wut_en || (wut_base && wut_cnt == 16'h0000)) begin
				wut_cnt <= wut_reload;
			end else if (wut_base) begin
				wut_cnt <= wut_cnt - 16'h0001;
			end
		end
	end

	// -----------------------------------------------------------------
	// backup words: no reset on purpose, so contents outlive any reset
	// -----------------------------------------------------------------
	wire bkp_hit = bkp_idx < 3'(rcb_pkg::BKP_WORDS);

	always_ff @(posedge clk_sys) begin
		if (rst_n && bkp_we && bkp_hit) begin
			bkp_mem[bkp_idx] <= bkp_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			bkp_rdata <= 32'h00000000;
		end else begin
			bkp_rdata <= bkp_hit ? bkp_mem[bkp_idx] : 32'h00000000;
		end
	end

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	property p_bkp_write;
		@(posedge clk_sys) disable iff (!rst_n)
		bkp_we && bkp_hit |=> bkp_mem[$past(bkp_idx)] == $past(bkp_wdata);
	endproperty
	a_bkp_write: assert property (p_bkp_write) else $error("backup write lost");

	property p_bkp_keep;
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(rst_n) |-> $stable(bkp_mem[0]);
	endproperty
	a_bkp_keep: assert property (p_bkp_keep) else $error("backup changed by reset");

	property p_sec_roll;
		@(posedge clk_sys) disable iff (!rst_n)
		tick && !cal_set && cal_now.sec == 7'h59
			|=> cal_now.sec == 7'h00 && cal_now.min != $past(cal_now.min);
	endproperty
	a_sec_roll: assert property (p_sec_roll) else $error("second rollover wrong");

	property p_month_len;
		@(posedge clk_sys) disable iff (!rst_n)
		day_carry && !cal_set && cal_now.date == month_end(cal_now.month, cal_now.year)
			|=> cal_now.date == 6'h01;
	endproperty
	a_month_len: assert property (p_month_len) else $error("month end missed");

	property p_alarm;
		@(posedge clk_sys) disable iff (!rst_n)
		tick ##1 (alarm_en[0] && alarm_hit(alarm_a, cal_now)) |=> flags.alra && wake_evt;
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm a not raised");

	property p_wut;
		@(posedge clk_sys) disable iff (!rst_n)
		wut_fire |=> flags.wut && wut_cnt == $past(wut_reload);
	endproperty
	a_wut: assert property (p_wut) else $error("wakeup timer wrong");

	property p_shift;
		@(posedge clk_sys) disable iff (!rst_n)
		shift_go && !shift_add1s && shift_sub != 15'h0000
			|=> shift_busy && shift_pend == {1'b0, $past(shift_sub)};
	endproperty
	a_shift: assert property (p_shift) else $error("shift not loaded");

	property p_ref;
		@(posedge clk_sys) disable iff (!rst_n)
		ref_en && ref_sec && !cal_set |=> cal_now.ss == $past(prediv);
	endproperty
	a_ref: assert property (p_ref) else $error("reference resync missed");

	property p_calib;
		@(posedge clk_sys) disable iff (!rst_n)
		src_pulse && {11'h000, cal_minus} > wcnt && !cal_plus |-> step == 2'h0;
	endproperty
	a_calib: assert property (p_calib) else $error("calibration mask missed");

	property p_tamp;
		@(posedge clk_sys) disable iff (!rst_n)
		pin_rise[rcb_pkg::PIN_TAMP0] && tamp_en[0] |=> flags.tamp[0] && flags.ts;
	endproperty
	a_tamp: assert property (p_tamp) else $error("tamper not flagged");

	property p_ts;
		@(posedge clk_sys) disable iff (!rst_n)
		ts_evt |=> ts_cal == $past(cal_now);
	endproperty
	a_ts: assert property (p_ts) else $error("timestamp not captured");

	property p_presc;
		@(posedge clk_sys) disable iff (!rst_n)
		!ref_en && step != 2'h0 && cal_now.ss == 15'h0000 |-> tick;
	endproperty
	a_presc: assert property (p_presc) else $error("second tick missed");

	c_alarm: cover property (@(posedge clk_sys) disable iff (!rst_n) alm_hit[0]);
	c_month: cover property (@(posedge clk_sys) disable iff (!rst_n)
		day_carry && cal_now.month == 5'h02);
	c_ts: cover property (@(posedge clk_sys) disable iff (!rst_n) ts_evt ##1 wake_evt);
	c_wut: cover property (@(posedge clk_sys) disable iff (!rst_n) wut_fire);
endmodule : rcb_top

// ### test/rcb_top_tb.sv
/*
 * self-checking bench of the calendar clock: backup words, rollover, alarms,
 * tamper, timestamp, wakeup timer, shift and source select.
 * assumes rcb_top with FAST_DIV set to 2 and pins driven slowly against clk_sys.
 */
`timescale 1ns/1ps
module rcb_top_tb;
	// -----------------------------------------------------------------
	// signals
	// -----------------------------------------------------------------
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic xtal = 1'b0, rc = 1'b0, fast = 1'b0, timestamp_pin = 1'b0;
	logic [1:0] tamper_pin = 2'h0, wut_sel = 2'h3, alarm_en = 2'h3, tamp_en = 2'h0;
	logic [1:0] tamp_filt = 2'h0;
	rcb_pkg::rcb_src_t src_sel = rcb_pkg::SRC_XTAL;
	logic [14:0] prediv = 15'h0003, shift_sub = 15'h0000;
	logic fmt_12h = 1'b0, ref_60hz = 1'b0, wut_en = 1'b0, ts_en = 1'b0;
	logic ref_pin = 1'b0, ref_en = 1'b0, cal_plus = 1'b0, shift_add1s = 1'b0;
	logic [8:0] cal_minus = 9'h000;
	logic cal_set = 1'b0, shift_req = 1'b0, bkp_we = 1'b0;
	logic [15:0] wut_reload = 16'h0001;
	rcb_pkg::rcb_alarm_t alarm_a = '0, alarm_b = '0;
	rcb_pkg::rcb_cal_t cal_wdata = '0, cal_now, ts_cal, exp_cal;
	logic [2:0] bkp_idx = 3'h0;
	logic [31:0] bkp_wdata = 32'h0, bkp_rdata;
	rcb_pkg::rcb_flags_t flags, flag_clr = '0;
	logic shift_busy, wake_evt;
	int num_errors = 0;
	int cmp_count = 0;

	// clock at 200 mhz
	always #2.5 clk_sys = ~clk_sys;

	rcb_top #(.FAST_DIV(2)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.slow_crystal_clock(xtal), .slow_internal_rc_clock(rc), .fast_external_clock(fast),
		.tamper_pin(tamper_pin), .timestamp_pin(timestamp_pin), .ref_clock_pin(ref_pin),
		.src_sel(src_sel), .prediv(prediv), .fmt_12h(fmt_12h), .cal_minus(cal_minus),
		.cal_plus(cal_plus), .ref_en(ref_en), .ref_60hz(ref_60hz), .wut_en(wut_en),
		.wut_sel(wut_sel), .wut_reload(wut_reload), .alarm_en(alarm_en),
		.alarm_a(alarm_a), .alarm_b(alarm_b), .tamp_en(tamp_en), .tamp_filt(tamp_filt),
		.ts_en(ts_en), .cal_set(cal_set), .cal_wdata(cal_wdata), .shift_req(shift_req),
		.shift_sub(shift_sub), .shift_add1s(shift_add1s),
		.bkp_we(bkp_we), .bkp_idx(bkp_idx),
		.bkp_wdata(bkp_wdata), .bkp_rdata(bkp_rdata), .cal_now(cal_now), .ts_cal(ts_cal),
		.flags(flags), .flag_clr(flag_clr), .shift_busy(shift_busy), .wake_evt(wake_evt));

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	// inputs always move 1 ns after the edge so no race with the design
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chk_cal(input string what, input rcb_pkg::rcb_cal_t exp,
		input rcb_pkg::rcb_cal_t got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_cal

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop

	// source pulses: high and low long enough for the two-flop synchroniser
	task automatic pulse(input int which, input int n);
		for (int i = 0; i < n; i++) begin
			case (which)
				0: xtal = 1'b1;
				1: rc = 1'b1;
				2: fast = 1'b1;
				default: ref_pin = 1'b1;
			endcase
			step(4);
			xtal = 1'b0;
			rc = 1'b0;
			fast = 1'b0;
			ref_pin = 1'b0;
			step(4);
		end
		step(4);
	endtask : pulse

	task automatic load(input rcb_pkg::rcb_cal_t c);
		cal_wdata = c;
		cal_set = 1'b1;
		step(1);
		cal_set = 1'b0;
	endtask : load

	task automatic clear_flags;
		flag_clr = '1;
		step(1);
		flag_clr = '0;
		step(1);
		chk("flags cleared", 32'h0, {26'h0, flags});
		chk("wake cleared", 32'h0, {31'h0, wake_evt});
	endtask : clear_flags

	task automatic bkp_read(input logic [2:0] idx, input logic [31:0] exp);
		bkp_idx = idx;
		step(2);
		chk("backup word", exp, bkp_rdata);
	endtask : bkp_read

	// one second before midnight, one pulse rolls the day over
	task automatic roll(input logic fmt, input logic [5:0] hr, input logic pm,
		input logic [5:0] dt, input logic [4:0] mo, input logic [7:0] yr,
		input logic [5:0] ehr, input logic epm, input logic [5:0] edt,
		input logic [4:0] emo, input logic [1:0] ealr);
		fmt_12h = fmt;
		load('{ss: 15'h0000, sec: 7'h59, min: 7'h59, pm: pm, hour: hr, wday: 3'h3,
			date: dt, month: mo, year: yr});
		clear_flags();
		exp_cal = '{ss: 15'h0003, sec: 7'h00, min: 7'h00, pm: epm, hour: ehr, wday: 3'h4,
			date: edt, month: emo, year: yr};
		pulse(0, 1);
		chk_cal("rollover", exp_cal, cal_now);
		chk("alarm flags", {30'h0, ealr}, {30'h0, flags.alrb, flags.alra});
		chk("alarm wake", {31'h0, ealr != 2'h0}, {31'h0, wake_evt});
	endtask : roll

	// -----------------------------------------------------------------
	// watchdog: the tests need well under 10k cycles
	// -----------------------------------------------------------------
	initial begin
		#250000;
		num_errors++;
		$display("ERROR watchdog expired");
		report_and_stop();
	end

	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial begin
		step(3);
		rst_n = 1'b1;
		chk_cal("reset calendar", rcb_pkg::CAL_RST, cal_now);
		chk("reset flags", 32'h0, {25'h0, flags, wake_evt});
		chk("reset busy", 32'h0, {31'h0, shift_busy});
		$display("test reset done");

		// backup words kept across a second reset, index 5 is not a word
		for (int i = 0; i < 6; i++) begin
			bkp_we = 1'b1;
			bkp_idx = 3'(i);
			bkp_wdata = 32'h5a5a0000 | i;
			step(1);
		end
		bkp_we = 1'b0;
		for (int i = 0; i < 6; i++) bkp_read(3'(i), (i < 5) ? (32'h5a5a0000 | i) : 32'h0);
		// a write held across reset must not land
		rst_n = 1'b0;
		bkp_we = 1'b1;
		bkp_idx = 3'h0;
		bkp_wdata = 32'h0bad0bad;
		step(3);
		rst_n = 1'b1;
		bkp_we = 1'b0;
		for (int i = 0; i < 5; i++) bkp_read(3'(i), 32'h5a5a0000 | i);
		$display("test backup done");

		// alarm a hits 00:00:00 on the 1st, alarm b 12:00:00 am on the 1st
		alarm_a = '{msk: 4'h0, sec: 7'h00, min: 7'h00, pm: 1'b0, hour: 6'h00, date: 6'h01};
		alarm_b = '{msk: 4'h0, sec: 7'h00, min: 7'h00, pm: 1'b0, hour: 6'h12, date: 6'h01};
		roll(0, 6'h23, 0, 6'h28, 5'h02, 8'h01, 6'h00, 0, 6'h01, 5'h03, 2'h1);
		roll(0, 6'h23, 0, 6'h28, 5'h02, 8'h04, 6'h00, 0, 6'h29, 5'h02, 2'h0);
		roll(0, 6'h23, 0, 6'h29, 5'h02, 8'h00, 6'h00, 0, 6'h01, 5'h03, 2'h1);
		roll(0, 6'h23, 0, 6'h30, 5'h04, 8'h01, 6'h00, 0, 6'h01, 5'h05, 2'h1);
		roll(1, 6'h11, 1, 6'h31, 5'h01, 8'h01, 6'h12, 0, 6'h01, 5'h02, 2'h2);
		$display("test calendar done");

		// tamper with filter, then timestamp pin, then a disabled tamper
		clear_flags();
		tamp_en = 2'h3;
		ts_en = 1'b1;
		tamp_filt = 2'h1;
		tamper_pin = 2'h2;
		step(10);
		chk("tamper flags", 32'h30, {26'h0, flags});
		chk("tamper wake", 32'h1, {31'h0, wake_evt});
		chk_cal("tamper stamp", exp_cal, ts_cal);
		tamper_pin = 2'h0;
		step(4);
		clear_flags();
		timestamp_pin = 1'b1;
		step(10);
		chk("stamp flags", 32'h20, {26'h0, flags});
		timestamp_pin = 1'b0;
		step(4);
		clear_flags();
		tamp_en = 2'h0;
		tamper_pin = 2'h1;
		step(10);
		chk("disabled tamper", 32'h0, {26'h0, flags});
		tamper_pin = 2'h0;
		$display("test events done");

		// wakeup on second ticks, period of reload plus one
		exp_cal.ss = 15'h0000;
		load(exp_cal);
		wut_en = 1'b1;
		pulse(0, 1);
		chk("wakeup early", 32'h0, {31'h0, flags.wut});
		pulse(0, 4);
		chk("wakeup fired", 32'h1, {31'h0, flags.wut});
		chk("wakeup wake", 32'h1, {31'h0, wake_evt});
		wut_en = 1'b0;
		clear_flags();
		$display("test wakeup done");

		// shift swallows two rc pulses, then source select
		exp_cal.ss = 15'h0003;
		load(exp_cal);
		src_sel = rcb_pkg::SRC_RC;
		shift_sub = 15'h0002;
		shift_req = 1'b1;
		step(1);
		shift_req = 1'b0;
		chk("shift busy", 32'h1, {31'h0, shift_busy});
		pulse(1, 2);
		chk("shift done", 32'h0, {31'h0, shift_busy});
		chk("ss after shift", 32'h3, {17'h0, cal_now.ss});
		src_sel = rcb_pkg::SRC_FAST;
		pulse(2, 2);
		chk("ss fast source", 32'h2, {17'h0, cal_now.ss});
		src_sel = rcb_pkg::rcb_src_t'(2'h3);
		ref_60hz = 1'b1;
		pulse(0, 1);
		pulse(1, 1);
		chk("ss no source", 32'h2, {17'h0, cal_now.ss});
		src_sel = rcb_pkg::SRC_XTAL;
		pulse(1, 1);
		chk("ss rc unselected", 32'h2, {17'h0, cal_now.ss});
		pulse(0, 1);
		chk("ss crystal", 32'h1, {17'h0, cal_now.ss});
		$display("test shift and source done");

		// reference: the 50th filtered edge gives the second and reloads ss
		ref_en = 1'b1;
		ref_60hz = 1'b0;
		pulse(3, 49);
		chk("ref early", 32'h0, {25'h0, cal_now.sec});
		pulse(3, 1);
		exp_cal.sec = 7'h01;
		chk_cal("ref second", exp_cal, cal_now);
		ref_en = 1'b0;
		// calibration: masked pulse, then a doubled pulse early in the window
		cal_minus = 9'h1ff;
		pulse(0, 1);
		chk("ss masked", 32'h3, {17'h0, cal_now.ss});
		cal_minus = 9'h000;
		cal_plus = 1'b1;
		pulse(0, 1);
		chk("ss doubled", 32'h1, {17'h0, cal_now.ss});
		cal_plus = 1'b0;
		// add one second now, then swallow prediv+1-1 pulses
		shift_sub = 15'h0001;
		shift_add1s = 1'b1;
		shift_req = 1'b1;
		step(1);
		shift_req = 1'b0;
		shift_add1s = 1'b0;
		chk("add1s busy", 32'h1, {31'h0, shift_busy});
		chk("add1s second", 32'h2, {25'h0, cal_now.sec});
		pulse(0, 3);
		chk("add1s done", 32'h0, {31'h0, shift_busy});
		chk("ss after add1s", 32'h1, {17'h0, cal_now.ss});
		$display("test reference, calibration and add second done");
		report_and_stop();
	end
endmodule : rcb_top_tb
